/* File: pkg/usrx_pkg.sv */
// Purpose: constants for the asynchronous serial receiver
// Assumes: 8-bit register port, 40 MHz system clock
// Notes:   offsets are register indexes on addr_in
`default_nettype none
package usrx_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [2:0] ADDR_STATUS  = 3'h0; // receive_status_reg
  localparam logic [2:0] ADDR_DATA    = 3'h1; // receive_data_reg
  localparam logic [2:0] ADDR_DIV_LO  = 3'h2; // baud_divisor_low
  localparam logic [2:0] ADDR_DIV_HI  = 3'h3; // baud_divisor_high
  localparam logic [2:0] ADDR_BAUDCTL = 3'h4; // baud_control_reg
  localparam logic [2:0] ADDR_MODE    = 3'h5; // mode and irq control
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int ST_SERIAL_PORT_ENABLE  = 7;
  localparam int ST_RX9   = 6;
  localparam int ST_SREN  = 5;
  localparam int ST_CONTINUOUS_RECEIVE_ENABLE  = 4;
  localparam int ST_ADDRESS_DETECT_ENABLE = 3;
  localparam int ST_FERR  = 2;
  localparam int ST_OERR  = 1;
  localparam int ST_RX9D  = 0;
  localparam int BC_ROLL  = 7;
  localparam int BC_IDLE  = 6;
  localparam int BC_RXPOL = 5;
  localparam int BC_CKPOL = 4;
  localparam int BC_WIDE  = 3;
  localparam int BC_WAKE  = 1;
  localparam int BC_ABD   = 0;
  localparam int MD_FLAG  = 7;
  localparam int MD_HS    = 2;
  localparam int MD_SYNC  = 1;
  localparam int MD_IE    = 0;
  // ---------------------------------------------------------------
  // reset values and timing counts
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_RST      = 8'h00;
  localparam logic [3:0] OS_LAST      = 4'hF; // 16 samples per bit
  localparam logic [3:0] OS_MID       = 4'h7; // middle of start bit
  localparam logic [3:0] BITS8_LAST   = 4'h7;
  localparam logic [3:0] BITS9_LAST   = 4'h8;
  localparam logic [1:0] PRE_SLOW     = 2'h3; // divide by 4 without high speed
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} usrx_state_t;
endpackage
`default_nettype wire

/* File: pkg/usrx_link_if.sv */
// Purpose: carrier between receiver, baud generator and line sync
// Assumes: single clock domain
// Notes:   none
`timescale 1ns/1ps
`default_nettype none
interface usrx_link_if;
  logic        run;
  logic        wide;
  logic        high_speed;
  logic        rx_invert;
  logic [15:0] divisor;
  logic        os_tick;
  logic        rx_line;
  modport gen  (input run, wide, high_speed, divisor, output os_tick);
  modport sync (input rx_invert, output rx_line);
  modport rx   (output run, wide, high_speed, divisor, rx_invert,
                input os_tick, rx_line);
endinterface
`default_nettype wire

/* File: core/usrx_baud_gen.sv */
// Purpose: 16x oversampling tick from the baud divisor
// Assumes: divisor stable while run is high
// Notes:   tick period is (divisor+1) clocks, low byte only unless wide, times 4 without high speed
`timescale 1ns/1ps
`default_nettype none
module usrx_baud_gen
  import usrx_pkg::*;
(
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  usrx_link_if.gen  lnk
);
  logic [1:0]  pre_q, pre_d;
  logic [15:0] cnt_q, cnt_d;
  logic        tick_q, tick_d;
  logic [15:0] div_w;

  // ---------------------------------------------------------------
  // divider; counters held at zero while run is low so the first tick is full
  // ---------------------------------------------------------------
  always_comb begin
    div_w  = lnk.wide ? lnk.divisor : {8'h00, lnk.divisor[7:0]};
    pre_d  = pre_q;
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (!lnk.run) begin
      pre_d = 2'h0;
      cnt_d = 16'h0000;
    end else if (pre_q != 2'h0) begin
      pre_d = pre_q - 2'h1;
    end else begin
      pre_d = lnk.high_speed ? 2'h0 : PRE_SLOW;
      if (cnt_q >= div_w) begin
        cnt_d  = 16'h0000;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pre_q  <= 2'h0;
      cnt_q  <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      pre_q  <= pre_d;
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign lnk.os_tick = tick_q;
endmodule // usrx_baud_gen
`default_nettype wire

/* File: core/usrx_line_sync.sv */
// Purpose: bring the receive pin into the clock domain
// Assumes: pin idles high (mark)
// Notes:   polarity applied after the synchroniser
`timescale 1ns/1ps
`default_nettype none
module usrx_line_sync
  import usrx_pkg::*;
(
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  input  wire logic rx_serial_pin_in,
  usrx_link_if.sync lnk
);
  logic meta_q, sync_q, line_q;
  logic line_d;

  // ---------------------------------------------------------------
  // two-stage sync; only the second stage feeds logic
  // ---------------------------------------------------------------
  always_comb begin
    line_d = sync_q ^ lnk.rx_invert;
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      line_q <= 1'b1;
    end else begin
      meta_q <= rx_serial_pin_in;
      sync_q <= meta_q;
      line_q <= line_d;
    end
  end

  assign lnk.rx_line = line_q;
endmodule // usrx_line_sync
`default_nettype wire

/* File: core/usrx_receiver.sv */
// Purpose: asynchronous serial receive path with address detect
// Assumes: 8-bit register port, read data one cycle after strobe
// Notes:   single-entry receive buffer
// Functional notes
// - receive pin goes through a recovery stage before the shifter
// - recovery stage samples every clock; framing samples at sixteen times the baud rate
// - receive shifter advances once per bit, not per sample
// - nine data bits when nine-bit receive is set, else eight
// - characters accepted only after continuous receive enable is set
// - receive flag on completion; irq only when irq enable set
// - status shows ninth bit and errors; read it before data
// - low eight bits of character shown in receive data register
// - clearing continuous receive enable clears a pending error
// - address detect active while enabled; needs nine-bit mode
// - address detect keeps non-address characters out, no irq
`timescale 1ns/1ps
`default_nettype none
module usrx_receiver
  import usrx_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  input  wire logic [2:0] addr_in,
  input  wire logic [7:0] wr_data_in,
  input  wire logic       wr_en_in,
  input  wire logic       rd_en_in,
  output var  logic [7:0] rd_data_out,
  input  wire logic       rx_serial_pin_in,
  output var  logic       serial_clock_pin_out,
  output var  logic       serial_clock_pin_oe_out,
  output var  logic       rx_irq_req_out
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  usrx_state_t state_q, state_d;
  logic [3:0]  os_cnt_q, os_cnt_d;
  logic [3:0]  bit_cnt_q, bit_cnt_d;
  logic [8:0]  shift_q, shift_d;
  logic        serial_port_enable_q, serial_port_enable_d, rx9_q, rx9_d, sren_q, sren_d;
  logic        continuous_receive_enable_q, continuous_receive_enable_d, address_detect_enable_q, address_detect_enable_d;
  logic        ferr_q, ferr_d, oerr_q, oerr_d, rx9d_q, rx9d_d;
  logic        flag_q, flag_d;
  logic [7:0]  data_q, data_d, div_lo_q, div_lo_d, div_hi_q, div_hi_d;
  logic        roll_q, roll_d, rxpol_q, rxpol_d, ckpol_q, ckpol_d;
  logic        wide_q, wide_d, wake_q, wake_d, abd_q, abd_d;
  logic        hs_q, hs_d, sync_q, sync_d, ie_q, ie_d;
  logic [7:0]  rd_data_q, rd_data_d;
  logic        irq_q, irq_d, ck_q, ck_d, ck_oe_q, ck_oe_d;
  logic        rx_en, char_done, stop_bit, accept, pop;
  logic [8:0]  ch;

  usrx_link_if lnk ();

  // ---------------------------------------------------------------
  // recovery stage and baud generator
  // ---------------------------------------------------------------
  usrx_line_sync u_sync (
    .sys_clk_in       (sys_clk_in),
    .rst_in           (rst_in),
    .rx_serial_pin_in (rx_serial_pin_in),
    .lnk              (lnk.sync)
  );

  usrx_baud_gen u_baud (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .lnk        (lnk.gen)
  );

  // overrun halts reception until the enable is toggled
  assign rx_en          = serial_port_enable_q & continuous_receive_enable_q & ~sync_q & ~oerr_q;
  assign lnk.run        = rx_en;
  assign lnk.wide       = wide_q;
  assign lnk.high_speed = hs_q;
  assign lnk.divisor    = {div_hi_q, div_lo_q};
  assign lnk.rx_invert  = rxpol_q;

  // ---------------------------------------------------------------
  // character framing
  // ---------------------------------------------------------------
  always_comb begin
    state_d   = state_q;
    os_cnt_d  = os_cnt_q;
    bit_cnt_d = bit_cnt_q;
    shift_d   = shift_q;
    char_done = 1'b0;
    stop_bit  = lnk.rx_line;
    case (state_q)
      RX_IDLE: begin
        if (lnk.os_tick && !lnk.rx_line) begin
          state_d  = RX_START;
          os_cnt_d = 4'h0;
        end
      end
      RX_START: begin
        if (lnk.os_tick) begin
          if (os_cnt_q == OS_MID) begin
            // glitch shorter than half a bit is rejected here
            state_d   = lnk.rx_line ? RX_IDLE : RX_DATA;
            os_cnt_d  = 4'h0;
            bit_cnt_d = 4'h0;
          end else begin
            os_cnt_d = os_cnt_q + 4'h1;
          end
        end
      end
      RX_DATA: begin
        if (lnk.os_tick) begin
          if (os_cnt_q == OS_LAST) begin
            os_cnt_d = 4'h0;
            shift_d  = {lnk.rx_line, shift_q[8:1]};
            if (bit_cnt_q == (rx9_q ? BITS9_LAST : BITS8_LAST)) begin
              state_d = RX_STOP;
            end else begin
              bit_cnt_d = bit_cnt_q + 4'h1;
            end
          end else begin
            os_cnt_d = os_cnt_q + 4'h1;
          end
        end
      end
      RX_STOP: begin
        if (lnk.os_tick) begin
          if (os_cnt_q == OS_LAST) begin
            state_d   = RX_IDLE;
            char_done = 1'b1;
          end else begin
            os_cnt_d = os_cnt_q + 4'h1;
          end
        end
      end
      default: state_d = RX_IDLE;
    endcase
    if (!rx_en) begin
      state_d   = RX_IDLE;
      char_done = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_q   <= RX_IDLE;
      os_cnt_q  <= 4'h0;
      bit_cnt_q <= 4'h0;
      shift_q   <= 9'h000;
    end else begin
      state_q   <= state_d;
      os_cnt_q  <= os_cnt_d;
      bit_cnt_q <= bit_cnt_d;
      shift_q   <= shift_d;
    end
  end

  // ---------------------------------------------------------------
  // register file and receive buffer
  // ---------------------------------------------------------------
  assign ch     = rx9_q ? shift_q : {1'b0, shift_q[8:1]};
  assign accept = char_done & ~(address_detect_enable_q & ~ch[8]);
  assign pop    = rd_en_in & (addr_in == ADDR_DATA);

  always_comb begin
    {serial_port_enable_d, rx9_d, sren_d, continuous_receive_enable_d, address_detect_enable_d} = {serial_port_enable_q, rx9_q, sren_q, continuous_receive_enable_q, address_detect_enable_q};
    {ferr_d, oerr_d, rx9d_d, flag_d, data_d} = {ferr_q, oerr_q, rx9d_q, flag_q, data_q};
    {div_lo_d, div_hi_d} = {div_lo_q, div_hi_q};
    {roll_d, rxpol_d, ckpol_d, wide_d, wake_d, abd_d} =
      {roll_q, rxpol_q, ckpol_q, wide_q, wake_q, abd_q};
    {hs_d, sync_d, ie_d} = {hs_q, sync_q, ie_q};
    if (wr_en_in) begin
      case (addr_in)
        ADDR_STATUS: begin
          serial_port_enable_d  = wr_data_in[ST_SERIAL_PORT_ENABLE];
          rx9_d   = wr_data_in[ST_RX9];
          sren_d  = wr_data_in[ST_SREN];
          continuous_receive_enable_d  = wr_data_in[ST_CONTINUOUS_RECEIVE_ENABLE];
          address_detect_enable_d = wr_data_in[ST_ADDRESS_DETECT_ENABLE];
          if (!wr_data_in[ST_CONTINUOUS_RECEIVE_ENABLE]) begin
            oerr_d = 1'b0;
            ferr_d = 1'b0;
          end
        end
        ADDR_DIV_LO: div_lo_d = wr_data_in;
        ADDR_DIV_HI: div_hi_d = wr_data_in;
        ADDR_BAUDCTL: begin
          roll_d  = roll_q & wr_data_in[BC_ROLL]; // clear only
          rxpol_d = wr_data_in[BC_RXPOL];
          ckpol_d = wr_data_in[BC_CKPOL];
          wide_d  = wr_data_in[BC_WIDE];
          wake_d  = wr_data_in[BC_WAKE];
          abd_d   = wr_data_in[BC_ABD];
        end
        ADDR_MODE: begin
          hs_d   = wr_data_in[MD_HS];
          sync_d = wr_data_in[MD_SYNC];
          ie_d   = wr_data_in[MD_IE];
        end
        default: ;
      endcase
    end
    // reading the data frees the buffer and its per-character error
    if (pop) begin
      flag_d = 1'b0;
      ferr_d = 1'b0;
    end
    // completion last so a same-cycle set beats any clear
    if (accept) begin
      if (flag_q && !pop) begin
        oerr_d = 1'b1;
      end else begin
        data_d = ch[7:0];
        rx9d_d = ch[8];
        ferr_d = ~stop_bit;
        flag_d = 1'b1;
      end
    end
  end

  // read mux; data valid only in the cycle after the strobe
  always_comb begin
    rd_data_d = 8'h00;
    if (rd_en_in) begin
      case (addr_in)
        ADDR_STATUS:  rd_data_d = {serial_port_enable_q, rx9_q, sren_q, continuous_receive_enable_q, address_detect_enable_q,
                                   ferr_q, oerr_q, rx9d_q};
        ADDR_DATA:    rd_data_d = data_q;
        ADDR_DIV_LO:  rd_data_d = div_lo_q;
        ADDR_DIV_HI:  rd_data_d = div_hi_q;
        ADDR_BAUDCTL: rd_data_d = {roll_q, state_q == RX_IDLE, rxpol_q, ckpol_q,
                                   wide_q, 1'b0, wake_q, abd_q};
        ADDR_MODE:    rd_data_d = {flag_q, 4'h0, hs_q, sync_q, ie_q};
        default:      rd_data_d = 8'h00;
      endcase
    end
    irq_d   = flag_q & ie_q;
    ck_d    = ckpol_q;
    ck_oe_d = serial_port_enable_q & sync_q;
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      {serial_port_enable_q, rx9_q, sren_q, continuous_receive_enable_q, address_detect_enable_q} <= 5'h00;
      {ferr_q, oerr_q, rx9d_q, flag_q} <= 4'h0;
      data_q    <= REG_RST;
      div_lo_q  <= REG_RST;
      div_hi_q  <= REG_RST;
      {roll_q, rxpol_q, ckpol_q, wide_q, wake_q, abd_q} <= 6'h00;
      {hs_q, sync_q, ie_q} <= 3'h0;
      rd_data_q <= 8'h00;
      {irq_q, ck_q, ck_oe_q} <= 3'h0;
    end else begin
      {serial_port_enable_q, rx9_q, sren_q, continuous_receive_enable_q, address_detect_enable_q} <= {serial_port_enable_d, rx9_d, sren_d, continuous_receive_enable_d, address_detect_enable_d};
      {ferr_q, oerr_q, rx9d_q, flag_q} <= {ferr_d, oerr_d, rx9d_d, flag_d};
      data_q    <= data_d;
      div_lo_q  <= div_lo_d;
      div_hi_q  <= div_hi_d;
      {roll_q, rxpol_q, ckpol_q, wide_q, wake_q, abd_q} <=
        {roll_d, rxpol_d, ckpol_d, wide_d, wake_d, abd_d};
      {hs_q, sync_q, ie_q} <= {hs_d, sync_d, ie_d};
      rd_data_q <= rd_data_d;
      {irq_q, ck_q, ck_oe_q} <= {irq_d, ck_d, ck_oe_d};
    end
  end

  assign rd_data_out             = rd_data_q;
  assign rx_irq_req_out          = irq_q;
  assign serial_clock_pin_out    = ck_q;
  assign serial_clock_pin_oe_out = ck_oe_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  property p_flag_set;
    accept && !flag_q |=> flag_q && data_q == $past(ch[7:0]);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");
  property p_irq;
    flag_q && ie_q |=> rx_irq_req_out;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");
  property p_no_irq;
    !ie_q ##1 !ie_q |-> !rx_irq_req_out;
  endproperty
  a_no_irq: assert property (p_no_irq) else $error("irq while disabled");
  property p_discard;
    char_done && address_detect_enable_q && !ch[8] && !flag_q && !oerr_q |=> !flag_q;
  endproperty
  a_discard: assert property (p_discard) else $error("data char kept");
  property p_overrun;
    accept && flag_q && !pop |=> oerr_q && data_q == $past(data_q);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun missed");
  property p_ferr;
    accept && !flag_q |=> ferr_q == !$past(stop_bit);
  endproperty
  a_ferr: assert property (p_ferr) else $error("framing flag wrong");
  property p_continuous_receive_enable_clear;
    wr_en_in && addr_in == ADDR_STATUS && !wr_data_in[ST_CONTINUOUS_RECEIVE_ENABLE] && !accept |=> !oerr_q ##1 !oerr_q;
  endproperty
  a_continuous_receive_enable_clear: assert property (p_continuous_receive_enable_clear) else $error("error not cleared");
  property p_gate;
    !rx_en |=> state_q == RX_IDLE;
  endproperty
  a_gate: assert property (p_gate) else $error("receiving while off");
  property p_bit_rate;
    $changed(shift_q) |-> $past(lnk.os_tick && os_cnt_q == OS_LAST);
  endproperty
  a_bit_rate: assert property (p_bit_rate) else $error("shift off bit rate");
  property p_ninth;
    accept && !flag_q && rx9_q |=> rx9d_q == $past(shift_q[8]);
  endproperty
  a_ninth: assert property (p_ninth) else $error("ninth bit wrong");
  property p_rdata;
    pop |=> rd_data_out == $past(data_q);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data wrong");
  property p_ck_idle;
    !ckpol_q ##1 !ckpol_q |-> !serial_clock_pin_out;
  endproperty
  a_ck_idle: assert property (p_ck_idle) else $error("clock idle not low");

  c_char: cover property (accept && !flag_q);
  c_overrun: cover property (accept && flag_q && !pop);
  c_address: cover property (char_done && address_detect_enable_q && ch[8]);
  c_ferr: cover property (accept && !stop_bit);
endmodule // usrx_receiver
`default_nettype wire

/* File: testbench/usrx_tx_model.sv */
// Purpose: remote asynchronous serial transmitter driving the receive pin
// Assumes: line idles at mark (high), bench picks the bit length in clocks
// Notes:   frames are sent by the send task; the line rests high between them
`timescale 1ns/1ps
`default_nettype none
module usrx_tx_model (
  input  wire logic clk_in,
  output var  logic line_out
);
  // --------------------------------------------------------------
  // frame generator
  // --------------------------------------------------------------
  initial line_out = 1'b1;

  // start bit, data lsb first, stop bit, then two bit times of mark
  task automatic send(input logic [8:0] data, input int nbits,
                      input logic stop_lvl, input int bit_clks);
    int i;
    @(posedge clk_in);
    line_out <= 1'b0;
    repeat (bit_clks) @(posedge clk_in);
    for (i = 0; i < nbits; i++) begin
      line_out <= data[i];
      repeat (bit_clks) @(posedge clk_in);
    end
    line_out <= stop_lvl;
    repeat (bit_clks) @(posedge clk_in);
    line_out <= 1'b1; // released line rests at mark
    repeat (2 * bit_clks) @(posedge clk_in);
  endtask
endmodule // usrx_tx_model
`default_nettype wire

/* File: testbench/tb_top.sv */
// Purpose: self-checking bench for the asynchronous serial receiver
// Assumes: 40 MHz clock, divisor 30 with high speed, so 16 ticks take 496 clocks
// Notes:   bit length is the midpoint of the two bit periods, 496 and 512 clocks
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import usrx_pkg::*;
;
  // --------------------------------------------------------------
  // signals and instances
  // --------------------------------------------------------------
  localparam int BIT_CLKS = 504;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdat = 8'h00;
  logic       wr_en = 1'b0;
  logic       rd_en = 1'b0;
  logic [7:0] rdat;
  logic       line;
  logic       sck;
  logic       sck_oe;
  logic       irq;
  int         errors = 0;
  int         check_count = 0;
  logic       line_invert = 1'b0;
  logic       pin;

  always #12.5 sys_clk = ~sys_clk;

  // far side can be flipped to try the inverted-line setting
  assign pin = line ^ line_invert;

  usrx_tx_model tx (.clk_in(sys_clk), .line_out(line));

  usrx_receiver dut (
    .sys_clk_in(sys_clk), .rst_in(rst), .addr_in(addr), .wr_data_in(wdat),
    .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rdat),
    .rx_serial_pin_in(pin), .serial_clock_pin_out(sck),
    .serial_clock_pin_oe_out(sck_oe), .rx_irq_req_out(irq));

  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdat <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 d = rdat;
  endtask

  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  task automatic stop_test;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  // reset values, read-only bits and unmapped indexes
  task automatic t_reset;
    logic [7:0] exp [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00};
    int i;
    wr(3'h7, 8'hFF);
    wr(ADDR_STATUS, 8'h07);
    for (i = 0; i < 8; i++) rchk(3'(i), exp[i]);
  endtask

  // configuration order; nothing is taken before continuous enable
  task automatic t_config;
    wr(ADDR_DIV_LO, 8'h1E);
    wr(ADDR_DIV_HI, 8'hFF);
    wr(ADDR_BAUDCTL, 8'h00);
    wr(ADDR_MODE, 8'h05);
    wr(ADDR_STATUS, 8'h80);
    tx.send(9'h05A, 8, 1'b1, BIT_CLKS);
    rchk(ADDR_MODE, 8'h05);
    wr(ADDR_STATUS, 8'h90);
  endtask

  // plain eight-bit character with interrupt enabled
  task automatic t_basic;
    tx.send(9'h0A5, 8, 1'b1, BIT_CLKS);
    chk({7'h00, irq}, 8'h01);
    rchk(ADDR_MODE, 8'h85);
    rchk(ADDR_STATUS, 8'h90);
    rchk(ADDR_DATA, 8'hA5);
    rchk(ADDR_MODE, 8'h05);
    chk({7'h00, irq}, 8'h00);
  endtask

  // flag without interrupt when the enable is clear
  task automatic t_masked;
    wr(ADDR_MODE, 8'h04);
    tx.send(9'h03C, 8, 1'b1, BIT_CLKS);
    rchk(ADDR_MODE, 8'h84);
    chk({7'h00, irq}, 8'h00);
    rchk(ADDR_DATA, 8'h3C);
    wr(ADDR_MODE, 8'h05);
  endtask

  // nine data bits, ninth shown in status
  task automatic t_nine;
    wr(ADDR_STATUS, 8'hD0);
    tx.send(9'h1C3, 9, 1'b1, BIT_CLKS);
    rchk(ADDR_STATUS, 8'hD1);
    rchk(ADDR_DATA, 8'hC3);
    wr(ADDR_STATUS, 8'h90);
  endtask

  // low stop bit, error cleared by dropping continuous enable
  task automatic t_framing;
    tx.send(9'h055, 8, 1'b0, BIT_CLKS);
    rchk(ADDR_STATUS, 8'h94);
    wr(ADDR_STATUS, 8'h80);
    rchk(ADDR_STATUS, 8'h80);
    rchk(ADDR_DATA, 8'h55);
    wr(ADDR_STATUS, 8'h90);
  endtask

  // second character while the buffer is still full
  task automatic t_overrun;
    tx.send(9'h011, 8, 1'b1, BIT_CLKS);
    tx.send(9'h022, 8, 1'b1, BIT_CLKS);
    rchk(ADDR_STATUS, 8'h92);
    rchk(ADDR_DATA, 8'h11);
    wr(ADDR_STATUS, 8'h80);
    rchk(ADDR_STATUS, 8'h80);
    wr(ADDR_STATUS, 8'h90);
  endtask

  // address detect drops data, takes address, then admits all
  task automatic t_address;
    wr(ADDR_STATUS, 8'hD8);
    tx.send(9'h012, 9, 1'b1, BIT_CLKS);
    rchk(ADDR_MODE, 8'h05);
    chk({7'h00, irq}, 8'h00);
    tx.send(9'h1A7, 9, 1'b1, BIT_CLKS);
    chk({7'h00, irq}, 8'h01);
    rchk(ADDR_STATUS, 8'hD9);
    rchk(ADDR_DATA, 8'hA7);
    wr(ADDR_STATUS, 8'hD0);
    tx.send(9'h034, 9, 1'b1, BIT_CLKS);
    rchk(ADDR_STATUS, 8'hD0);
    rchk(ADDR_DATA, 8'h34);
  endtask

  // slow prescale, wide divisor and inverted line, set up while off
  task automatic t_alt_link;
    wr(ADDR_STATUS, 8'h80);
    wr(ADDR_DIV_LO, 8'h07);
    wr(ADDR_DIV_HI, 8'h00);
    line_invert <= 1'b1;
    wr(ADDR_BAUDCTL, 8'h28);
    wr(ADDR_MODE, 8'h01);
    wr(ADDR_STATUS, 8'h90);
    tx.send(9'h096, 8, 1'b1, BIT_CLKS);
    rchk(ADDR_BAUDCTL, 8'h68);
    rchk(ADDR_DATA, 8'h96);
    wr(ADDR_STATUS, 8'h80);
    line_invert <= 1'b0;
    wr(ADDR_BAUDCTL, 8'h00);
    wr(ADDR_DIV_LO, 8'h1E);
    wr(ADDR_MODE, 8'h05);
    wr(ADDR_STATUS, 8'h90);
  endtask

  // clocked mode: serial clock pin idle level follows polarity
  task automatic t_clock_pin;
    wr(ADDR_MODE, 8'h07);
    repeat (2) @(posedge sys_clk);
    #1 chk({6'h00, sck_oe, sck}, 8'h02);
    wr(ADDR_BAUDCTL, 8'h10);
    repeat (2) @(posedge sys_clk);
    #1 chk({6'h00, sck_oe, sck}, 8'h03);
  endtask

  // --------------------------------------------------------------
  // main sequence and watchdog
  // --------------------------------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_config();
    t_basic();
    t_masked();
    t_nine();
    t_framing();
    t_overrun();
    t_address();
    t_alt_link();
    t_clock_pin();
    stop_test();
  end

  // about 11 frames of 12 bit times fit well inside this span
  initial begin
    repeat (95000) @(posedge sys_clk);
    errors++;
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
